// [include/cmbf_pkg.sv]
/*
 Shared constants and carriers for the CAN message buffer block: register
 indices, status and control bit positions, frame field widths and bit timing.
 Assumes an APB register bus with 32-bit data and a 10 MHz pclk.
*/
package cmbf_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_CTRL     = 6'h01;
   localparam logic [5:0] IDX_STATUS   = 6'h02;
   localparam logic [5:0] IDX_WIN_LO   = 6'h10;  // Descriptor byte
   localparam logic [5:0] IDX_ID1      = 6'h11;
   localparam logic [5:0] IDX_ID2      = 6'h12;
   localparam logic [5:0] IDX_ID3      = 6'h13;
   localparam logic [5:0] IDX_ID4      = 6'h14;
   localparam logic [5:0] IDX_DATA_STD = 6'h13;  // Data byte 1, standard
   localparam logic [5:0] IDX_DATA_EXT = 6'h15;  // Data byte 1, extended
   localparam logic [5:0] IDX_WIN_HI   = 6'h1c;
   localparam int         BUF_BYTES    = 13;
   // Descriptor fields
   localparam int         DESC_FF      = 7;
   localparam int         DESC_RTR     = 6;
   localparam logic [3:0] DLC_MAX      = 4'h8;
   // Control bits (pulse on write) and status bits
   localparam int         CTRL_TX_REQ  = 0;
   localparam int         CTRL_RX_REL  = 1;
   localparam int         ST_TX_BUSY   = 0;
   localparam int         ST_ARB_LOST  = 1;
   localparam int         ST_RX_FULL   = 2;
   localparam int         ST_TX_DONE   = 3;
   localparam int         ST_RX_DROP   = 4;
   // Identifier lengths and serial frame length
   localparam int         ID_STD_BITS  = 11;
   localparam int         ID_EXT_BITS  = 29;
   localparam int         SER_BITS     = 98;   // 29 id + rtr + 4 dlc + 64 data
   // Bit timing
   localparam int         CLK_NS       = 100;
   localparam int         BIT_NS       = 1000;
   localparam int         BIT_CYC      = (BIT_NS + CLK_NS - 1) / CLK_NS;

   // One received frame as delivered by the protocol engine
   typedef struct packed {
      logic             ff;
      logic             rtr;
      logic [3:0]       dlc;
      logic [28:0]      id;
      logic [7:0][7:0]  data;   // data[0] is data byte 1
   } cmbf_frame_s;
endpackage

// [rtl/cmbf_top.sv]
/*
 CAN message buffer: one 13-byte transmit buffer, a one-message receive
 window, and a bit serializer that sends the buffered frame with arbitration.
 Assumes an APB master on pclk, a protocol engine on pclk delivering received
 frames, and an asynchronous bus receive pin that is synchronised here.
*/
// Register access over APB was left to the implementer.
// What this block does
// - Descriptor bit 7 selects extended (1) or standard (0) frame format.
// - Descriptor bit 6 set sends a remote frame, clear sends data frame.
// - Remote frames carry zero data bytes regardless of length field.
// - Data byte count is descriptor bits 3:0, unsigned, range zero to eight.
// - Length above eight sends eight bytes; length field sent as written.
// - Standard uses identifier bits 28..18, extended uses bits 28..0.
// - Identifier bit 28 goes first, then lower bits descending.
// - Lower identifier wins arbitration; dominant zero beats recessive one.
// - Data starts with MSB of data byte 1 at index 19 or 21.
// - Standard id from index 17 and bits 7:5 of index 18.
// - Extended id from indices 17..19 and bits 7:3 of index 20.
// - Oldest received message is readable at indices 16 through 28.
// - Received descriptor: format, remote, zeros in 5:4, length in 3:0.
// - Standard receive index 18: id 20..18, remote bit 4, zeros below.
// - Extended receive indices 17,18 hold id 28..21 and 20..13.
// - Extended receive index 19 id 12..5; index 20 id 4..0, remote, zeros.
// - Received length reported as sent; at most eight data bytes stored.
// - Transmit buffer holds one 13-byte message at indices 16..28.
`timescale 1ns/1ps
module cmbf_top #(
   parameter int ADDR_W  = 8,
   parameter int BIT_DIV = cmbf_pkg::BIT_CYC
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [ADDR_W-1:0]    paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 can_rx_in,
   output logic                      can_tx_out,
   input  wire logic                 rx_valid,
   input  wire cmbf_pkg::cmbf_frame_s rx_frame,
   output logic                      rx_ready
);
   initial begin
      if (ADDR_W < 8 || BIT_DIV < 2) $error("cmbf_top: unsupported parameters");
   end

   // Receive window byte for an index, laid out by frame format
   function automatic logic [7:0] win_byte(cmbf_pkg::cmbf_frame_s f, logic [5:0] i);
      logic [7:0] b;
      logic [5:0] d;
      b = 8'h00;
      d = f.ff ? (i - cmbf_pkg::IDX_DATA_EXT) : (i - cmbf_pkg::IDX_DATA_STD);
      if (i == cmbf_pkg::IDX_WIN_LO)
         b = {f.ff, f.rtr, 2'b00, f.dlc};
      else if (i == cmbf_pkg::IDX_ID1)
         b = f.id[28:21];
      else if (i == cmbf_pkg::IDX_ID2 && !f.ff)
         b = {f.id[20:18], f.rtr, 4'h0};
      else if (i == cmbf_pkg::IDX_ID2)
         b = f.id[20:13];
      else if (i == cmbf_pkg::IDX_ID3 && f.ff)
         b = f.id[12:5];
      else if (i == cmbf_pkg::IDX_ID4 && f.ff)
         b = {f.id[4:0], f.rtr, 2'b00};
      else if (d < 6'd8)
         b = f.data[d[2:0]];
      return b;
   endfunction

   // Number of data bytes a frame really carries
   function automatic logic [3:0] data_cnt(logic rtr, logic [3:0] dlc);
      logic [3:0] n;
      n = (dlc > cmbf_pkg::DLC_MAX) ? cmbf_pkg::DLC_MAX : dlc;
      return rtr ? 4'h0 : n;
   endfunction

   logic [7:0]            txb_q [cmbf_pkg::BUF_BYTES];
   cmbf_pkg::cmbf_frame_s rx_q;
   logic                  rx_full_q;
   logic                  rx_drop_q;
   logic                  tx_act_q;
   logic                  arb_lost_q;
   logic                  tx_done_q;
   logic [cmbf_pkg::SER_BITS-1:0] sh_q;
   logic [6:0]            bits_q;
   logic [4:0]            arb_q;
   logic [15:0]           div_q;
   logic                  rx_m_q;
   logic                  rx_s_q;

   // APB decode; the slave always answers in the access cycle
   wire logic [5:0] idx      = paddr[7:2];
   // Shift keeps the check legal when the address is exactly one byte wide
   wire logic       hi_zero  = (paddr >> 8) == '0;
   wire logic       aligned  = (paddr[1:0] == 2'b00) && hi_zero;
   wire logic       in_win   = (idx >= cmbf_pkg::IDX_WIN_LO) && (idx <= cmbf_pkg::IDX_WIN_HI);
   wire logic       is_ctrl  = idx == cmbf_pkg::IDX_CTRL;
   wire logic       is_stat  = idx == cmbf_pkg::IDX_STATUS;
   wire logic       mapped   = aligned && (in_win || is_ctrl || is_stat);
   wire logic       acc      = psel && penable;
   wire logic       wr_win   = acc && pwrite && aligned && in_win;
   wire logic       wr_ctrl  = acc && pwrite && aligned && is_ctrl;
   wire logic [3:0] win_off  = 4'(idx - cmbf_pkg::IDX_WIN_LO);
   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;

   // Status word is the block's own state
   wire logic [7:0] status = {3'b000, rx_drop_q, tx_done_q, rx_full_q, arb_lost_q, tx_act_q};
   wire logic [7:0] rd_byte = !aligned ? 8'h00 :
                              in_win   ? (rx_full_q ? win_byte(rx_q, idx) : 8'h00) :
                              is_stat  ? status : 8'h00;
   assign prdata = {24'h00_0000, rd_byte};

   // Transmit buffer load, one message of 13 bytes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < cmbf_pkg::BUF_BYTES; k++) txb_q[k] <= 8'h00;
      end else if (wr_win && !tx_act_q) begin
         txb_q[win_off] <= pwdata[7:0];
      end
   end

   // Transmit frame assembly from the buffer
   wire logic        t_ff   = txb_q[0][cmbf_pkg::DESC_FF];
   wire logic        t_rtr  = txb_q[0][cmbf_pkg::DESC_RTR];
   wire logic [3:0]  t_dlc  = txb_q[0][3:0];
   wire logic [10:0] id_std = {txb_q[1], txb_q[2][7:5]};
   wire logic [28:0] id_ext = {txb_q[1], txb_q[2], txb_q[3], txb_q[4][7:3]};
   wire logic [63:0] d_std  = {txb_q[3], txb_q[4], txb_q[5], txb_q[6],
                               txb_q[7], txb_q[8], txb_q[9], txb_q[10]};
   wire logic [63:0] d_ext  = {txb_q[5], txb_q[6], txb_q[7], txb_q[8],
                               txb_q[9], txb_q[10], txb_q[11], txb_q[12]};
   wire logic [3:0]  t_n    = data_cnt(t_rtr, t_dlc);
   wire logic [cmbf_pkg::SER_BITS-1:0] ser_std = {id_std, t_rtr, t_dlc, d_std, 18'h0_0000};
   wire logic [cmbf_pkg::SER_BITS-1:0] ser_ext = {id_ext, t_rtr, t_dlc, d_ext};
   wire logic [4:0]  id_len = t_ff ? 5'(cmbf_pkg::ID_EXT_BITS) : 5'(cmbf_pkg::ID_STD_BITS);
   wire logic [6:0]  t_bits = 7'(id_len) + 7'd5 + {t_n, 3'b000};
   wire logic        tx_go  = wr_ctrl && pwdata[cmbf_pkg::CTRL_TX_REQ] && !tx_act_q;

   // Bus receive pin synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_m_q <= 1'b1;
         rx_s_q <= 1'b1;
      end else begin
         rx_m_q <= can_rx_in;
         rx_s_q <= rx_m_q;
      end
   end

   // Bit time enable from a divider; restarts with each frame
   wire logic bit_en = tx_act_q && (div_q == 16'(BIT_DIV - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) div_q <= 16'h0000;
      else if (!tx_act_q || bit_en) div_q <= 16'h0000;
      else div_q <= div_q + 16'h0001;
   end

   // Recessive one sent but dominant zero seen while in arbitration
   wire logic in_arb = arb_q != 5'h00;
   wire logic lose   = bit_en && in_arb && sh_q[cmbf_pkg::SER_BITS-1] && !rx_s_q;
   wire logic last   = bit_en && (bits_q == 7'h01);

   // Serializer: MSB first, identifier then rtr, length and data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_act_q   <= 1'b0;
         sh_q       <= '0;
         bits_q     <= 7'h00;
         arb_q      <= 5'h00;
      end else if (tx_go) begin
         tx_act_q   <= 1'b1;
         sh_q       <= t_ff ? ser_ext : ser_std;
         bits_q     <= t_bits;
         arb_q      <= id_len;
      end else if (lose || last) begin
         tx_act_q   <= 1'b0;
         arb_q      <= 5'h00;
      end else if (bit_en) begin
         sh_q       <= {sh_q[cmbf_pkg::SER_BITS-2:0], 1'b0};
         bits_q     <= bits_q - 7'h01;
         arb_q      <= in_arb ? arb_q - 5'h01 : 5'h00;
      end
   end
   assign can_tx_out = tx_act_q ? sh_q[cmbf_pkg::SER_BITS-1] : 1'b1;

   // Sticky transmit outcome; a new request clears both
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arb_lost_q <= 1'b0;
         tx_done_q  <= 1'b0;
      end else begin
         arb_lost_q <= lose || (arb_lost_q && !tx_go);
         tx_done_q  <= last || (tx_done_q && !tx_go);
      end
   end

   // Receive window: one held message, released by software.
   // A frame arriving in the release cycle is taken, so none is lost.
   wire logic rel = wr_ctrl && pwdata[cmbf_pkg::CTRL_RX_REL];
   assign rx_ready = !rx_full_q || rel;
   wire logic take = rx_valid && rx_ready;
   wire logic [3:0] r_n = data_cnt(rx_frame.rtr, rx_frame.dlc);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_q      <= '0;
         rx_full_q <= 1'b0;
         rx_drop_q <= 1'b0;
      end else begin
         if (take) begin
            rx_q.ff  <= rx_frame.ff;
            rx_q.rtr <= rx_frame.rtr;
            rx_q.dlc <= rx_frame.dlc;
            rx_q.id  <= rx_frame.ff ? rx_frame.id : {rx_frame.id[28:18], 18'h0_0000};
            for (int k = 0; k < 8; k++)
               rx_q.data[k] <= (4'(k) < r_n) ? rx_frame.data[k] : 8'h00;
         end
         rx_full_q <= take || (rx_full_q && !rel);
         rx_drop_q <= (rx_valid && !rx_ready) || (rx_drop_q && !rel);
      end
   end

   // Checks
   logic [10:0] id_start;
   assign id_start = t_ff ? id_ext[28:18] : id_std;
   wire logic rd_acc = acc && !pwrite && aligned && rx_full_q;

   sequence s_go;
      tx_go;
   endsequence
   sequence s_lost_bit;
      lose;
   endsequence

   chk_idle_recessive: assert property (@(posedge pclk) disable iff (!presetn)
      !tx_act_q |-> can_tx_out) else $error("idle bus not recessive");
   chk_first_id_msb: assert property (@(posedge pclk) disable iff (!presetn)
      s_go |=> can_tx_out == $past(id_start[10])) else $error("first bit not id 28");
   chk_bit_count: assert property (@(posedge pclk) disable iff (!presetn)
      s_go |=> bits_q == 7'($past(id_len)) + 7'd5 + ($past(t_rtr) ? 7'd0 :
               ($past(t_dlc) > 4'h8 ? 7'd64 : 7'({$past(t_dlc), 3'b000}))))
      else $error("wrong frame bit count");
   chk_arb_lost: assert property (@(posedge pclk) disable iff (!presetn)
      s_lost_bit |=> !tx_act_q && arb_lost_q ##1 can_tx_out) else $error("arbitration loss");
   chk_rx_desc: assert property (@(posedge pclk) disable iff (!presetn)
      rd_acc && idx == cmbf_pkg::IDX_WIN_LO |-> prdata[7:0] == {rx_q.ff, rx_q.rtr, 2'b00,
      rx_q.dlc}) else $error("rx descriptor layout");
   chk_rx_std_id2: assert property (@(posedge pclk) disable iff (!presetn)
      rd_acc && !rx_q.ff && idx == cmbf_pkg::IDX_ID2 |-> prdata[4] == rx_q.rtr &&
      prdata[3:0] == 4'h0) else $error("rx standard id2 layout");
   chk_rx_ext_id4: assert property (@(posedge pclk) disable iff (!presetn)
      rd_acc && rx_q.ff && idx == cmbf_pkg::IDX_ID4 |-> prdata[2] == rx_q.rtr &&
      prdata[1:0] == 2'b00) else $error("rx extended id4 layout");
   chk_rx_dlc_kept: assert property (@(posedge pclk) disable iff (!presetn)
      take |=> rx_q.dlc == $past(rx_frame.dlc) && rx_full_q) else $error("rx length changed");
   chk_rx_rtr_nodata: assert property (@(posedge pclk) disable iff (!presetn)
      take && rx_frame.rtr |=> rx_q.data == '0) else $error("remote frame kept data");
   chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      acc && !mapped |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped answer");

   // Further steps of a transfer, used by the properties below
   sequence s_rel;
      rel;
   endsequence
   sequence s_done_bit;
      last;
   endsequence

   // Slave never stretches an access; the master waits anyway
   chk_pready_high: assert property (@(posedge pclk) disable iff (!presetn)
      acc |-> pready) else $error("access not answered");

   // A window write lands in the buffer only while idle
   chk_load_word: assert property (@(posedge pclk) disable iff (!presetn)
      wr_win && !tx_act_q && win_off == 4'h0 |=> txb_q[0] == $past(pwdata[7:0]))
      else $error("buffer byte not loaded");

   // Start of a frame: busy set, old outcome flags cleared
   chk_busy_after_go: assert property (@(posedge pclk) disable iff (!presetn)
      s_go |=> tx_act_q && !tx_done_q && !arb_lost_q) else $error("start not taken");
   chk_frame_format: assert property (@(posedge pclk) disable iff (!presetn)
      s_go |=> arb_q == ($past(t_ff) ? 5'(cmbf_pkg::ID_EXT_BITS) :
               5'(cmbf_pkg::ID_STD_BITS))) else $error("identifier length");
   chk_rtr_tx_len: assert property (@(posedge pclk) disable iff (!presetn)
      s_go && t_rtr |=> bits_q == 7'($past(id_len)) + 7'd5)
      else $error("remote frame has data");

   // Each bit time moves the next stream bit onto the pin
   chk_shift_msb: assert property (@(posedge pclk) disable iff (!presetn)
      bit_en && !lose && !last |=> can_tx_out == $past(sh_q[cmbf_pkg::SER_BITS-2]))
      else $error("serial order");
   chk_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
      s_done_bit |=> !tx_act_q && tx_done_q && can_tx_out) else $error("frame end");

   // Held message stays until released; release empties the window
   chk_rx_full_stays: assert property (@(posedge pclk) disable iff (!presetn)
      rx_full_q && !rel |=> rx_full_q) else $error("held message lost");
   chk_rx_release: assert property (@(posedge pclk) disable iff (!presetn)
      s_rel && !rx_valid |=> !rx_full_q) else $error("release ignored");
   chk_rx_ready_full: assert property (@(posedge pclk) disable iff (!presetn)
      rx_full_q && !rel |-> !rx_ready) else $error("offer accepted while full");
   chk_rx_drop_flag: assert property (@(posedge pclk) disable iff (!presetn)
      rx_valid && !rx_ready |=> rx_drop_q) else $error("drop not flagged");

   // Standard frames keep no extended identifier bits
   chk_std_rx_id: assert property (@(posedge pclk) disable iff (!presetn)
      take && !rx_frame.ff |=> rx_q.id[17:0] == 18'h0_0000) else $error("std id tail");

   // Window byte layout as software reads it
   chk_rx_id1: assert property (@(posedge pclk) disable iff (!presetn)
      rd_acc && idx == cmbf_pkg::IDX_ID1 |-> prdata[7:0] == rx_q.id[28:21])
      else $error("rx id1 layout");
   chk_rx_ext_id2: assert property (@(posedge pclk) disable iff (!presetn)
      rd_acc && rx_q.ff && idx == cmbf_pkg::IDX_ID2 |-> prdata[7:0] == rx_q.id[20:13])
      else $error("rx extended id2 layout");
   chk_rx_ext_id3: assert property (@(posedge pclk) disable iff (!presetn)
      rd_acc && rx_q.ff && idx == cmbf_pkg::IDX_ID3 |-> prdata[7:0] == rx_q.id[12:5])
      else $error("rx extended id3 layout");

   // An empty window reads as zero, so stale bytes never leak
   chk_rx_empty_zero: assert property (@(posedge pclk) disable iff (!presetn)
      acc && !pwrite && aligned && in_win && !rx_full_q |-> prdata == 32'h0000_0000)
      else $error("empty window not zero");
endmodule // cmbf_top

// [tb/cmbf_node_model.sv]
/*
 Model of another CAN node on the bus: during one frame it sends an 11-bit
 identifier against the block, and it is recessive at all other times.
 Assumes go is high at the edge that starts the block's own transmission.
*/
`timescale 1ns/1ps
module cmbf_node_model #(
   parameter int DIV = 4
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        go,
   input  wire logic [10:0] nid,
   input  wire logic        dut_tx,
   output logic             bus
);
   logic       act_q;
   logic [3:0] idx_q;
   logic [7:0] cnt_q;

   // Wired-AND bus level, dominant zero wins; identifier sent MSB first
   assign bus = dut_tx & (act_q ? nid[4'd10 - idx_q] : 1'b1);

   // Bit pacing aligned to the block's first bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_q <= 1'b0;
         idx_q <= 4'h0;
         cnt_q <= 8'h00;
      end else if (go) begin
         act_q <= 1'b1;
         idx_q <= 4'h0;
         cnt_q <= 8'h00;
      end else if (act_q) begin
         cnt_q <= (cnt_q == 8'(DIV - 1)) ? 8'h00 : cnt_q + 8'h01;
         if (cnt_q == 8'(DIV - 1)) begin
            idx_q <= idx_q + 4'h1;
            act_q <= (idx_q != 4'ha);
         end
      end
   end
endmodule  // cmbf_node_model

// [tb/tb_can_message_buffer_format.sv]
/*
 Self-checking bench for the CAN message buffer: transmit bit streams,
 arbitration loss, receive window layout and an unmapped access.
 Assumes the package and the top module are compiled first.
*/
`timescale 1ns/1ps
module tb_can_message_buffer_format;
   localparam int D = 4;  // Short bit time keeps the run brief
   logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic                  can_tx_out, bus, rx_valid, rx_ready, go, arm, err;
   logic [7:0]            paddr;
   logic [31:0]           pwdata, prdata, rd;
   cmbf_pkg::cmbf_frame_s rx_frame;
   logic [10:0]           nid;
   logic [7:0]            b [13];
   int                    fail_count, total_checks, cyc;
   bit                    q [$];

   cmbf_top #(.ADDR_W(8), .BIT_DIV(D)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .can_rx_in(bus), .can_tx_out(can_tx_out),
      .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready));
   cmbf_node_model #(.DIV(D)) i_node (.pclk(pclk), .presetn(presetn), .go(go), .nid(nid),
      .dut_tx(can_tx_out), .bus(bus));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // Hang guard, well above the length of all tests
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         fail_count++;
         close_out();
      end
   end

   task automatic close_out;
      if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   // One APB transfer on word index i; idle cycle first avoids double drives
   task automatic apb(input logic w, input int i, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= 8'(i * 4);
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      go      <= arm;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      go      <= 1'b0;
   endtask

   // Load buffer, start, and compare each serial bit with the model stream; when lose is set, only wait and check status
   task automatic tx(input logic [7:0] desc, input logic lose);
      logic [28:0] idv;
      int          n;
      b[0] = desc;
      for (int i = 1; i < 13; i++) b[i] = 8'($urandom);
      b[1][7] = lose;
      for (int i = 0; i < 13; i++) apb(1'b1, 16 + i, {24'h0, b[i]});
      idv = b[0][7] ? {b[1], b[2], b[3], b[4][7:3]} : {b[1], b[2][7:5], 18'h0};
      q.delete();
      for (int j = 0; j < (b[0][7] ? 29 : 11); j++) q.push_back(idv[28 - j]);
      q.push_back(b[0][6]);
      for (int j = 0; j < 4; j++) q.push_back(b[0][3 - j]);
      n = b[0][6] ? 0 : (b[0][3:0] > 4'h8 ? 8 : int'(b[0][3:0]));
      for (int j = 0; j < n * 8; j++) q.push_back(b[(b[0][7] ? 5 : 3) + j / 8][7 - j % 8]);
      arm = lose;
      apb(1'b1, 1, 32'h0000_0001);
      arm = 1'b0;
      if (!lose) foreach (q[j]) begin
         @(negedge pclk);
         chk("tx bit", {31'h0, q[j]}, {31'h0, can_tx_out});
         repeat (D) @(posedge pclk);
      end
      else repeat (D * 4) @(posedge pclk);
      apb(1'b0, 2, 32'h0);
      chk("tx status", lose ? 32'h2 : 32'h8, rd & 32'h0000_000b);
      chk("tx idle", 32'h1, {31'h0, can_tx_out});
   endtask

   // Offer one frame, then read the whole window against the layout model
   task automatic rx(input logic ext, input logic rtr, input logic [3:0] dlc);
      logic [28:0] id;
      logic [63:0] dt;
      logic [7:0]  e [13];
      int          n;
      int          bs;
      id = 29'($urandom);
      dt = {$urandom, $urandom};
      rx_frame <= {ext, rtr, dlc, id, dt};
      rx_valid <= 1'b1;
      @(posedge pclk);
      rx_valid <= 1'b0;
      @(negedge pclk);
      chk("rx ready full", 32'h0, {31'h0, rx_ready});
      foreach (e[i]) e[i] = 8'h00;
      n = rtr ? 0 : (dlc > 4'h8 ? 8 : int'(dlc));
      e[0] = {ext, rtr, 2'b00, dlc};
      e[1] = id[28:21];
      e[2] = ext ? id[20:13] : {id[20:18], rtr, 4'h0};
      e[3] = ext ? id[12:5] : 8'h00;
      e[4] = ext ? {id[4:0], rtr, 2'b00} : 8'h00;
      bs = ext ? 5 : 3;
      for (int k = 0; k < n; k++) e[bs + k] = dt[8 * k +: 8];
      for (int i = 0; i < 13; i++) begin
         apb(1'b0, 16 + i, 32'h0);
         chk("rx window", {24'h0, e[i]}, rd);
      end
      apb(1'b1, 1, 32'h0000_0002);
      apb(1'b0, 2, 32'h0);
      chk("rx released", 32'h0, rd & 32'h0000_0004);
      chk("rx ready empty", 32'h1, {31'h0, rx_ready});
      chk("pready", 32'h1, {31'h0, pready});
   endtask

   // Main sequence
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, rx_valid, go, arm} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      rx_frame = '0;
      nid = 11'h000;
      void'($urandom(64978));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk("reset tx", 32'h1, {31'h0, can_tx_out});
      tx(8'h03, 1'b0);
      tx(8'h8a, 1'b0);
      tx(8'h45, 1'b0);
      tx(8'hc8, 1'b0);
      tx(8'h00, 1'b0);
      tx(8'($urandom) & 8'hcf, 1'b0);
      tx(8'h02, 1'b1);
      rx(1'b0, 1'b0, 4'h3);
      rx(1'b1, 1'b0, 4'hc);
      rx(1'b0, 1'b1, 4'h5);
      rx(1'b1, 1'b1, 4'h8);
      rx(1'b0, 1'b0, 4'($urandom));
      apb(1'b0, 63, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped read", 32'h0, rd);
      close_out();
   end
endmodule  // tb_can_message_buffer_format
